// [hw/sac_map.svh]
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// register byte addresses
`define SAC_ADDR_CONTROL   8'hD2
`define SAC_ADDR_RES_HIGH  8'hD3
`define SAC_ADDR_RES_LOW   8'hD4
`define SAC_ADDR_REFSEL    8'hD5
`define SAC_ADDR_ISOLATION 8'h9E
`define SAC_ADDR_IRQ_EN    8'h9A
`define SAC_ADDR_IRQ_REQ   8'hBF
// control register fields
`define SAC_CTL_ENABLE     7
`define SAC_CTL_START      6
`define SAC_CTL_DONE       5
`define SAC_SEL_HI         3
// result/config fields
`define SAC_CFG_GATE       6
`define SAC_CFG_CLK_HI     5
`define SAC_CFG_CLK_LO     4
// reference select
`define SAC_REF_SUPPLY_BIT 2
// input selector codes
`define SAC_SEL_LAST_PIN   4'h5
`define SAC_SEL_SUPPLY     4'h6
`define SAC_SEL_GROUND     4'h7
`define SAC_SEL_INTERNAL   4'h8
// clock select codes
`define SAC_CKS_DIV16      2'h0
`define SAC_CKS_DIV8       2'h1
`define SAC_CKS_DIV1       2'h2
`define SAC_CKS_DIV2       2'h3
`define SAC_DIV16_TERM     4'hF
`define SAC_DIV8_TERM      4'h7
`define SAC_DIV2_TERM      4'h1
`define SAC_DIV1_TERM      4'h0
// conversion length in converter clocks
`define SAC_CONV_CYCLES    7'h40
`endif

// [hw/sac_pkg.sv]
`default_nettype none
package sac_pkg;
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_CONV = 2'b01
    } sac_state_type;
    typedef enum logic [1:0] {
        SAC_REF_2V     = 2'b00,
        SAC_REF_3V     = 2'b01,
        SAC_REF_4V     = 2'b10,
        SAC_REF_SUPPLY = 2'b11
    } sac_ref_type;
endpackage
`default_nettype wire

// [hw/sac_tick.sv]
`include "sac_map.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// converter clock enable from the oscillator by the clock selector
module sac_tick
    import sac_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // control
    input  wire logic       run,
    input  wire logic [1:0] clk_sel,
    // tick out
    output logic            tick
);
    typedef struct packed {
        logic [3:0] cnt;
    } sac_tick_st_type;

    sac_tick_st_type st_reg;
    sac_tick_st_type st_next;
    logic [3:0]      term;

    always_comb begin
        case (clk_sel)
            `SAC_CKS_DIV16: term = `SAC_DIV16_TERM;
            `SAC_CKS_DIV8:  term = `SAC_DIV8_TERM;
            `SAC_CKS_DIV1:  term = `SAC_DIV1_TERM;
            default:        term = `SAC_DIV2_TERM;
        endcase
        tick = run && (st_reg.cnt >= term);
        st_next = st_reg;
        if (!run || tick) begin
            st_next.cnt = 4'h0;
        end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// [hw/sac_ctrl.sv]
`include "sac_map.svh"
`default_nettype none
module sac_ctrl
    import sac_pkg::*;
#(
    parameter int PIN_COUNT   = 6,
    parameter int RESULT_BITS = 12
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // avalon-mm slave
    input  wire logic [7:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic [1:0]                  avs_response,
    // analog front end
    output logic [PIN_COUNT-1:0]        pin_route,
    output logic                        route_supply,
    output logic                        route_ground,
    output logic                        route_internal,
    output logic [PIN_COUNT-1:0]        pin_analog_isolation,
    output logic [PIN_COUNT-1:0]        pin_digital_in_enable,
    output sac_ref_type                 reference_level,
    output logic                        converter_powered,
    output logic                        sample_strobe,
    input  wire logic [RESULT_BITS-1:0] analog_code,
    // interrupt controller
    input  wire logic                   isr_enter,
    output logic                        converter_irq
);
    initial begin
        if (PIN_COUNT < 1 || PIN_COUNT > 6) begin
            $error("PIN_COUNT out of range");
        end
        if (RESULT_BITS != 12) begin
            $error("RESULT_BITS must be 12");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        sac_state_type           state;
        logic                    enable;
        logic                    start;
        logic                    done;
        logic [3:0]              input_selector;
        logic                    global_channel_gate;
        logic [1:0]              clk_sel;
        logic [2:0]              ref_sel;
        logic [PIN_COUNT-1:0]    isolation;
        logic                    irq_enable;
        logic                    irq_flag;
        logic [RESULT_BITS-1:0]  result;
        logic [6:0]              count;
        logic                    ack;
        logic [7:0]              rdata;
        logic                    err;
    } sac_st_type;

    sac_st_type st_reg;
    sac_st_type st_next;
    logic       tick;
    logic       wr_lane;
    logic [7:0] wd;
    logic       finish;
    logic       hit;
    logic [7:0] rd_val;

    sac_tick u_tick (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .run      (st_reg.state == SAC_CONV),
        .clk_sel  (st_reg.clk_sel),
        .tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // routing and reference
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            assign pin_route[gi] = st_reg.global_channel_gate
                && (st_reg.input_selector == 4'(gi));
            assign pin_digital_in_enable[gi] = !st_reg.isolation[gi];
        end
    endgenerate

    assign route_supply   = st_reg.global_channel_gate
        && (st_reg.input_selector == `SAC_SEL_SUPPLY);
    assign route_ground   = st_reg.global_channel_gate
        && (st_reg.input_selector == `SAC_SEL_GROUND);
    assign route_internal = st_reg.global_channel_gate
        && (st_reg.input_selector == `SAC_SEL_INTERNAL);
    assign pin_analog_isolation = st_reg.isolation;
    assign reference_level = st_reg.ref_sel[`SAC_REF_SUPPLY_BIT]
        ? SAC_REF_SUPPLY : sac_ref_type'(st_reg.ref_sel[1:0]);
    assign converter_powered = st_reg.enable;
    assign sample_strobe     = finish;
    assign converter_irq     = st_reg.irq_flag && st_reg.irq_enable;

    ////////////////////////////////////////////////////////////////////////////
    // bus responses
    assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
    assign avs_readdata    = {24'h000000, st_reg.rdata};
    assign avs_response    = st_reg.err ? 2'h2 : 2'h0;
    assign wr_lane = avs_write && avs_byteenable[0] && !st_reg.ack;
    assign wd      = avs_writedata[7:0];
    assign finish  = (st_reg.state == SAC_CONV) && tick
        && (st_reg.count == `SAC_CONV_CYCLES - 7'h1);

    always_comb begin
        hit    = 1'b1;
        rd_val = 8'h00;
        if (avs_address == `SAC_ADDR_CONTROL) begin
            rd_val = {st_reg.enable, st_reg.start, st_reg.done,
                      1'b0, st_reg.input_selector};
        end else if (avs_address == `SAC_ADDR_RES_HIGH) begin
            rd_val = st_reg.result[11:4];
        end else if (avs_address == `SAC_ADDR_RES_LOW) begin
            rd_val = {1'b0, st_reg.global_channel_gate, st_reg.clk_sel,
                      st_reg.result[3:0]};
        end else if (avs_address == `SAC_ADDR_REFSEL) begin
            rd_val = {5'h00, st_reg.ref_sel};
        end else if (avs_address == `SAC_ADDR_ISOLATION) begin
            rd_val = 8'(st_reg.isolation);
        end else if (avs_address == `SAC_ADDR_IRQ_EN) begin
            rd_val = {7'h00, st_reg.irq_enable};
        end else if (avs_address == `SAC_ADDR_IRQ_REQ) begin
            rd_val = {7'h00, st_reg.irq_flag};
        end else begin
            hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next       = st_reg;
        st_next.ack   = (avs_read || avs_write) && !st_reg.ack;
        if ((avs_read || avs_write) && !st_reg.ack) begin
            st_next.rdata = avs_read ? rd_val : 8'h00;
            st_next.err   = !hit;
        end
        if (wr_lane) begin
            if (avs_address == `SAC_ADDR_CONTROL) begin
                st_next.enable         = wd[`SAC_CTL_ENABLE];
                st_next.input_selector = wd[`SAC_SEL_HI:0];
                if (!wd[`SAC_CTL_DONE]) begin
                    st_next.done = 1'b0;
                end
                if (wd[`SAC_CTL_START] && wd[`SAC_CTL_ENABLE]
                    && st_reg.state == SAC_IDLE) begin
                    st_next.start = 1'b1;
                    st_next.state = SAC_CONV;
                    st_next.count = 7'h00;
                end
            end else if (avs_address == `SAC_ADDR_RES_LOW) begin
                st_next.global_channel_gate = wd[`SAC_CFG_GATE];
                st_next.clk_sel = wd[`SAC_CFG_CLK_HI:`SAC_CFG_CLK_LO];
            end else if (avs_address == `SAC_ADDR_REFSEL) begin
                st_next.ref_sel = wd[2:0];
            end else if (avs_address == `SAC_ADDR_ISOLATION) begin
                st_next.isolation = wd[PIN_COUNT-1:0];
            end else if (avs_address == `SAC_ADDR_IRQ_EN) begin
                st_next.irq_enable = wd[0];
            end else if (avs_address == `SAC_ADDR_IRQ_REQ) begin
                st_next.irq_flag = wd[0];
            end
        end
        if (isr_enter) begin
            st_next.irq_flag = 1'b0;
        end
        case (st_reg.state)
            SAC_IDLE: begin
            end
            SAC_CONV: begin
                if (!st_next.enable) begin
                    st_next.state = SAC_IDLE;
                    st_next.start = 1'b0;
                end else if (finish) begin
                    st_next.state    = SAC_IDLE;
                    st_next.start    = 1'b0;
                    st_next.done     = 1'b1;
                    st_next.irq_flag = 1'b1;
                    st_next.result   = analog_code;
                end else if (tick) begin
                    st_next.count = st_reg.count + 7'h1;
                end
            end
            default: begin
                st_next.state = SAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg        <= '0;
            st_reg.state  <= SAC_IDLE;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// [verif/sac_ctrl_sva.sv]
`default_nettype none
module sac_ctrl_sva
    import sac_pkg::*;
#(
    parameter int PIN_COUNT = 6
) (
    // clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    // bus
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic                 avs_waitrequest,
    // front end
    input wire logic [PIN_COUNT-1:0] pin_route,
    input wire logic                 route_supply,
    input wire logic                 route_ground,
    input wire logic                 route_internal,
    input wire logic [PIN_COUNT-1:0] pin_analog_isolation,
    input wire logic [PIN_COUNT-1:0] pin_digital_in_enable,
    input wire logic                 converter_powered,
    input wire logic                 sample_strobe,
    // interrupt
    input wire logic                 isr_enter,
    input wire logic                 converter_irq
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
sequence s_wait; (avs_read || avs_write) && avs_waitrequest; endsequence
sequence s_quiet; !sample_strobe [*8]; endsequence
property p_wait_one; s_wait |=> !avs_waitrequest; endproperty
property p_one_route;
    $onehot0({pin_route, route_supply, route_ground, route_internal});
endproperty
property p_iso; pin_digital_in_enable == ~pin_analog_isolation; endproperty
property p_power; !converter_powered |-> !sample_strobe; endproperty
property p_pulse; sample_strobe |=> !sample_strobe; endproperty
property p_gap; sample_strobe |=> s_quiet; endproperty
property p_isr; isr_enter && !sample_strobe |=> !converter_irq; endproperty
property p_hold;
    converter_irq && !isr_enter && !avs_write |=> converter_irq;
endproperty
a_wait_one: assert property (p_wait_one) else $error("wait too long");
a_one_route: assert property (p_one_route) else $error("routes");
a_iso: assert property (p_iso) else $error("digital path");
a_power: assert property (p_power) else $error("strobe off");
a_pulse: assert property (p_pulse) else $error("strobe long");
a_gap: assert property (p_gap) else $error("conversion short");
a_isr: assert property (p_isr) else $error("irq kept");
a_hold: assert property (p_hold) else $error("irq lost");
endmodule
bind sac_ctrl sac_ctrl_sva #(.PIN_COUNT(PIN_COUNT)) chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .pin_route(pin_route), .route_supply(route_supply),
    .route_ground(route_ground), .route_internal(route_internal),
    .pin_analog_isolation(pin_analog_isolation),
    .pin_digital_in_enable(pin_digital_in_enable),
    .converter_powered(converter_powered), .sample_strobe(sample_strobe),
    .isr_enter(isr_enter), .converter_irq(converter_irq));
`default_nettype wire

// [verif/sac_ctrl_tb.sv]
`include "sac_map.svh"
`default_nettype none
module sac_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sac_pkg::*;
    logic        core_clk, rst_n, avs_read, avs_write, isr_enter;
    logic [7:0]  avs_address, rd;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0]  avs_response, rsp;
    logic [5:0]  pin_route, iso, din;
    logic [11:0] analog_code;
    logic        sup, gnd, intv, avs_waitrequest, pwr, strobe, irq;
    sac_ref_type reference_level;
    int          mismatches = 0;
    int          checked = 0;
    sac_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .pin_route(pin_route), .route_supply(sup), .route_ground(gnd),
        .route_internal(intv), .pin_analog_isolation(iso),
        .pin_digital_in_enable(din), .reference_level(reference_level),
        .converter_powered(pwr), .sample_strobe(strobe),
        .analog_code(analog_code), .isr_enter(isr_enter),
        .converter_irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        @(negedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(negedge core_clk);
        end
        if (n == 20) mismatches++;
        rd = avs_readdata[7:0];
        rsp = avs_response;
        @(posedge core_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("TB: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic t_reset_route;
        bus(0, `SAC_ADDR_RES_LOW, 8'h00);
        chk("gate_reset", 16'h0, rd & 8'h70);
        bus(1, 8'h10, 8'h55);
        chk("unmapped", 16'h2, rsp);
        bus(1, `SAC_ADDR_CONTROL, 8'h03);
        chk("gated", 16'h0, {pin_route, sup, gnd, intv});
        bus(1, `SAC_ADDR_RES_LOW, 8'h40);
        for (int k = 0; k < 10; k++) begin
            bus(1, `SAC_ADDR_CONTROL, 8'(k));
            chk("route", k < 6 ? 9'(1 << (k + 3)) : k < 9 ? 9'(1 << (8 - k))
                : 9'h0, {pin_route, sup, gnd, intv});
        end
        bus(1, `SAC_ADDR_ISOLATION, 8'h2A);
        chk("isolation", 16'h2A, iso);
        chk("digital_in", 16'h15, din);
        for (int v = 0; v < 8; v++) if (v != 3) begin
            bus(1, `SAC_ADDR_REFSEL, 8'(v));
            chk("reference", v[2] ? 2'b11 : 2'(v), reference_level);
        end
    endtask
    task automatic t_conv;
        logic [11:0] codes [4] = '{12'hFFF, 12'h000, 12'hA5C, 12'h123};
        int          divs [4] = '{16, 8, 1, 2};
        int          n;
        bus(1, `SAC_ADDR_IRQ_EN, 8'h01);
        bus(1, `SAC_ADDR_REFSEL, 8'h04);
        for (int s = 0; s < 4; s++) begin
            analog_code <= codes[s];
            bus(1, `SAC_ADDR_RES_LOW, 8'h40 | 8'(s << 4));
            bus(1, `SAC_ADDR_CONTROL, 8'hC5);
            n = 0;
            while (irq !== 1'b1 && n < 1200) begin
                n++;
                @(negedge core_clk);
            end
            chk("conv_time", 16'h1, n >= 63 * divs[s] - 2
                && n <= 65 * divs[s]);
            chk("powered", 16'h1, pwr);
            bus(0, `SAC_ADDR_CONTROL, 8'h00);
            chk("ctl_done", 16'hA5, rd);
            bus(0, `SAC_ADDR_RES_HIGH, 8'h00);
            chk("res_high", codes[s][11:4], rd);
            bus(0, `SAC_ADDR_RES_LOW, 8'h00);
            chk("res_low", 8'h40 | 8'(s << 4) | codes[s][3:0], rd);
            bus(0, `SAC_ADDR_IRQ_REQ, 8'h00);
            chk("irq_flag", 16'h1, rd[0]);
            isr_enter <= 1'b1;
            @(posedge core_clk);
            isr_enter <= 1'b0;
            @(posedge core_clk);
            chk("irq_clear", 16'h0, irq);
            bus(1, `SAC_ADDR_CONTROL, 8'h85);
            bus(0, `SAC_ADDR_CONTROL, 8'h00);
            chk("done_clear", 16'h85, rd);
        end
        bus(1, `SAC_ADDR_CONTROL, 8'h45);
        repeat (100) @(posedge core_clk);
        chk("idle_irq", 16'h0, irq);
        chk("unpowered", 16'h0, pwr);
        bus(0, `SAC_ADDR_CONTROL, 8'h00);
        chk("idle_done", 16'h0, rd & 8'h20);
        bus(0, `SAC_ADDR_RES_HIGH, 8'h00);
        chk("idle_result", 16'h12, rd);
    endtask
    initial begin
        {avs_read, avs_write, isr_enter, rst_n} = 4'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        analog_code = 12'h000;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset_route();
        t_conv();
        tally_and_finish();
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
